/* File: owd_pkg.sv */
package owd_pkg;

  // Width of every nonvolatile option word.
  localparam int OPT_W = 13;

  // Word 0 field positions.
  localparam int W0_NR_MODE  = 12;
  localparam int W0_NR_WIDTH = 11;
  localparam int W0_NR_DIS   = 10;
  localparam int W0_CYC_SEL  = 9;
  localparam int W0_PER_HI   = 8;
  localparam int W0_PER_LO   = 7;
  localparam int W0_WDT_EN   = 6;
  localparam int W0_OSC_HI   = 5;
  localparam int W0_OSC_LO   = 3;
  localparam int W0_PROT_HI  = 2;
  localparam int W0_PROT_LO  = 0;

  // Word 1 field positions.
  localparam int W1_TRIM_HI  = 8;
  localparam int W1_TRIM_LO  = 4;
  localparam int W1_FREQ_HI  = 3;
  localparam int W1_FREQ_LO  = 2;

  // Values held before the first capture: every documented default.
  localparam logic [12:0] W0_RESET = 13'h0000;
  localparam logic [12:0] W1_RESET = 13'h1200;
  localparam logic [12:0] W2_RESET = 13'h0000;

  // Oscillator mode codes.
  localparam logic [2:0] OSC_XT   = 3'h0;
  localparam logic [2:0] OSC_HXT  = 3'h1;
  localparam logic [2:0] OSC_LOW_CRYSTAL_OSC_1 = 3'h2;
  localparam logic [2:0] OSC_LOW_CRYSTAL_OSC_2 = 3'h3;

  // Internal RC selector and trim defaults.
  localparam logic [1:0] FREQ_DEF = 2'h0;
  localparam logic [4:0] TRIM_DEF = 5'h00;
  localparam int         TRIM_DIR = 3;

  // Nominal internal RC rates in kHz, one per selector code.
  localparam logic [13:0] KHZ_SEL0 = 14'h0fa0;
  localparam logic [13:0] KHZ_SEL1 = 14'h2ee0;
  localparam logic [13:0] KHZ_SEL2 = 14'h0dfc;
  localparam logic [13:0] KHZ_SEL3 = 14'h01c7;

  // Oscillator clocks per instruction for each period code.
  localparam logic [4:0] PER_CLK0 = 5'h04;
  localparam logic [4:0] PER_CLK1 = 5'h02;
  localparam logic [4:0] PER_CLK2 = 5'h08;
  localparam logic [4:0] PER_CLK3 = 5'h10;

  // Noise filter least pulse widths in filter clocks.
  localparam int NR_SHORT_CLKS = 8;
  localparam int NR_LONG_CLKS  = 32;

  // Cycles spent filling the option synchronisers before capture.
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  typedef enum logic [2:0] {
    ST_SETTLE  = 3'b001,
    ST_CAPTURE = 3'b010,
    ST_RUN     = 3'b100
  } owd_state_t;

endpackage

/* File: owd_noise_filter.sv */
`timescale 1ns/1ps
module owd_noise_filter #(
  parameter int SHORT_CLKS = 8,
  parameter int LONG_CLKS  = 32
) (
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic bypass_i,
  input  wire logic short_sel_i,
  output logic      level_o,
  output logic      fall_o
);
  import owd_pkg::*;

  initial begin
    if (SHORT_CLKS < 1 || LONG_CLKS < SHORT_CLKS || LONG_CLKS > 255)
      $error("Noise filter widths out of range.");
  end

  logic       pin_meta;
  logic       pin_sync;
  logic [7:0] stable_cnt;
  logic [7:0] width_m1;
  logic       differs;
  logic       accept;
  logic       next_level;

  // Unless bypassed, a new level is taken only after it has held for the chosen width.
  assign width_m1   = short_sel_i ? 8'(SHORT_CLKS - 1) : 8'(LONG_CLKS - 1);
  assign differs    = pin_sync != level_o;
  assign accept     = bypass_i || (differs && stable_cnt >= width_m1);
  assign next_level = accept ? pin_sync : level_o;

  // Two stages guard the pin; the first stage is read only by the second.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta   <= 1'b1;
      pin_sync   <= 1'b1;
      stable_cnt <= 8'h00;
      level_o    <= 1'b1;
      fall_o     <= 1'b0;
    end else begin
      pin_meta   <= pin_i;
      pin_sync   <= pin_meta;
      stable_cnt <= (differs && !accept) ? stable_cnt + 8'h01 : 8'h00;
      level_o    <= next_level;
      fall_o     <= level_o & ~next_level;
    end
  end

endmodule

/* File: owd_rc_trim.sv */
`timescale 1ns/1ps
module owd_rc_trim (
  input  wire logic [4:0]        trim_code_i,
  input  wire logic [1:0]        freq_sel_i,
  output logic signed [5:0]      trim_step_o,
  output logic [13:0]            nominal_khz_o
);
  import owd_pkg::*;

  logic [3:0] mag;
  logic       slower;

  // The direction bit splits the codes; magnitude is the other four bits.
  assign slower = trim_code_i[TRIM_DIR];
  assign mag    = {trim_code_i[4], trim_code_i[2:0]};

  // Slower codes start one step below nominal, so all ones is -16.
  assign trim_step_o = slower ? -$signed({2'b00, mag}) - 6'sh01
                              : $signed({2'b00, mag});

  always_comb begin
    unique case (freq_sel_i)
      2'h0: nominal_khz_o = KHZ_SEL0;
      2'h1: nominal_khz_o = KHZ_SEL1;
      2'h2: nominal_khz_o = KHZ_SEL2;
      2'h3: nominal_khz_o = KHZ_SEL3;
    endcase
  end

endmodule

/* File: owd_option_decoder.sv */
// Overview of operation
// - Default RC selector runs internal RC at 4MHz.
// - Selector offers 12MHz, 3.58MHz and 455kHz too.
// - Five-bit code trims every RC setting.
// - Zero nominal; direction bit slows, else speeds.
// - Option bits unreachable by running program.
// - Three 13-bit words; word 2 customer value.
// - Bit 12 picks noise rejection mode 2/1.
// - Bit 11 picks 8 or 32 clock pulse.
// - Filtered external interrupt triggers on falling edge.
// - Bit 10 disables filter; low crystal forces off.
// - Filter bypassed in 32 kHz crystal, sleep.
// - Bit 9 picks one or two instruction cycles.
// - Bits 8:7 give 4, 2, 8, 16 clocks.
// - Bit 6 enables the watchdog timer.
// - Bits 5:3 select the oscillator source.
// - RC modes: low bit picks pin I/O or clock.
// - Bits 2:0 control code protection.
// - Selector 00/01/10/11: 4M, 12M, 3.58M, 455k.
// - Trim code sits in word 1 bits 8:4.
`timescale 1ns/1ps
module owd_option_decoder #(
  parameter int NR_SHORT = owd_pkg::NR_SHORT_CLKS,
  parameter int NR_LONG  = owd_pkg::NR_LONG_CLKS
) (
  input  wire logic                     core_clk_i,
  input  wire logic                     arst_n_i,
  input  wire logic [owd_pkg::OPT_W-1:0] opt_word0_i,
  input  wire logic [owd_pkg::OPT_W-1:0] opt_word1_i,
  input  wire logic [owd_pkg::OPT_W-1:0] opt_word2_i,
  input  wire logic                     sleep_mode_i,
  input  wire logic                     ext_int_pin_i,
  output logic                          opt_loaded_o,
  output logic [owd_pkg::OPT_W-1:0]      customer_id_o,
  output logic                          noise_reject_mode_sel_o,
  output logic                          noise_pulse_width_sel_o,
  output logic                          noise_filter_disable_o,
  output logic                          noise_filter_active_o,
  output logic                          ext_int_level_o,
  output logic                          ext_int_fall_o,
  output logic                          single_cycle_sel_o,
  output logic [4:0]                    instr_period_clks_o,
  output logic                          watchdog_enable_opt_o,
  output logic [2:0]                    osc_mode_o,
  output logic                          crystal_osc_o,
  output logic                          high_crystal_osc_o,
  output logic                          low_crystal_osc_1_o,
  output logic                          low_crystal_osc_2_o,
  output logic                          internal_rc_osc_o,
  output logic                          external_rc_osc_o,
  output logic                          rc_clock_output_o,
  output logic                          code_protect_o,
  output logic [1:0]                    rc_freq_sel_o,
  output logic [4:0]                    rc_trim_code_o,
  output logic signed [5:0]             rc_trim_step_o,
  output logic [13:0]                   rc_nominal_khz_o
);
  import owd_pkg::*;

  initial begin
    if (NR_SHORT < 1 || NR_LONG < NR_SHORT)
      $error("Noise filter widths must be positive and ordered.");
    // The filter counts in eight bits, so longer widths cannot be served.
    if (NR_LONG > 255)
      $error("Noise filter width exceeds the counter range.");
  end

  // Reset release and option synchronisers.
  logic            rst_meta;
  logic            rst_n;
  logic [OPT_W-1:0] w0_meta;
  logic [OPT_W-1:0] w1_meta;
  logic [OPT_W-1:0] w2_meta;
  logic [OPT_W-1:0] w0_sync;
  logic [OPT_W-1:0] w1_sync;
  logic [OPT_W-1:0] w2_sync;

  // Captured option words and capture sequencing.
  logic [OPT_W-1:0] word0;
  logic [OPT_W-1:0] word1;
  logic [OPT_W-1:0] word2;
  owd_state_t       state;
  owd_state_t       next_state;
  logic [1:0]       settle_cnt;
  logic             capture;

  // Decoded fields of word 0.
  logic       nr_mode;
  logic       nr_short;
  logic       nr_dis_bit;
  logic       cyc_one;
  logic [1:0] per_code;
  logic       wdt_en;
  logic [2:0] osc_code;
  logic [2:0] prot_bits;

  // Decoded fields of word 1 and derived controls.
  logic [1:0]        freq_raw;
  logic [4:0]        trim_raw;
  logic              is_rc;
  logic              is_irc;
  logic              is_erc;
  logic              is_lxt;
  logic              nr_bypass;
  logic [4:0]        per_clks;
  logic [1:0]        freq_eff;
  logic [4:0]        trim_eff;
  logic signed [5:0] step_w;
  logic [13:0]       khz_w;
  logic              filt_level;
  logic              filt_fall;
  logic              is_xt;
  logic              is_hxt;
  logic              is_low_crystal_osc_1;
  logic              is_low_crystal_osc_2;
  logic              rc_out_sel;
  logic              prot_on;
  logic              run_now;

  // The asynchronous reset is released through two flip-flops so that
  // every register below leaves reset on the same clean edge.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // The option store sits outside this clock domain, so its words pass
  // two stages; the first stage feeds nothing but the second.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      w0_meta <= W0_RESET;
      w1_meta <= W1_RESET;
      w2_meta <= W2_RESET;
      w0_sync <= W0_RESET;
      w1_sync <= W1_RESET;
      w2_sync <= W2_RESET;
    end else begin
      w0_meta <= opt_word0_i;
      w1_meta <= opt_word1_i;
      w2_meta <= opt_word2_i;
      w0_sync <= w0_meta;
      w1_sync <= w1_meta;
      w2_sync <= w2_meta;
    end
  end

  // Capture sequence: wait for the synchronisers to fill, take the
  // words once, then stay in run until the next reset.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_SETTLE: begin
        if (settle_cnt == SETTLE_CYCLES - 2'h1) begin
          next_state = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        next_state = ST_RUN;
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_SETTLE;
      end
    endcase
  end

  assign capture = state == ST_CAPTURE;

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state      <= ST_SETTLE;
      settle_cnt <= 2'h0;
    end else begin
      state      <= next_state;
      settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 2'h1 : 2'h0;
    end
  end

  // The words are taken exactly once per reset. There is no path from the
  // instruction side, so a running program can neither read nor alter
  // them, and later changes on the store inputs are ignored.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      word0 <= W0_RESET;
      word1 <= W1_RESET;
      word2 <= W2_RESET;
    end else if (capture) begin
      word0 <= w0_sync;
      word1 <= w1_sync;
      word2 <= w2_sync;
    end
  end

  // Word 0 field extraction.
  assign nr_mode    = word0[W0_NR_MODE];
  assign nr_short   = word0[W0_NR_WIDTH];
  assign nr_dis_bit = word0[W0_NR_DIS];
  assign cyc_one    = word0[W0_CYC_SEL];
  assign per_code   = word0[W0_PER_HI:W0_PER_LO];
  assign wdt_en     = word0[W0_WDT_EN];
  assign osc_code   = word0[W0_OSC_HI:W0_OSC_LO];
  assign prot_bits  = word0[W0_PROT_HI:W0_PROT_LO];

  // Word 1 field extraction; the trim code's top bit is word bit 8.
  assign freq_raw = word1[W1_FREQ_HI:W1_FREQ_LO];
  assign trim_raw = word1[W1_TRIM_HI:W1_TRIM_LO];

  // Oscillator class decode. Codes with the top bit set are RC modes;
  // the middle bit then splits internal from external RC.
  assign is_rc  = osc_code[2];
  assign is_irc = is_rc && !osc_code[1];
  assign is_erc = is_rc && osc_code[1];
  assign is_xt   = osc_code == OSC_XT;
  assign is_hxt  = osc_code == OSC_HXT;
  assign is_low_crystal_osc_1 = osc_code == OSC_LOW_CRYSTAL_OSC_1;
  assign is_low_crystal_osc_2 = osc_code == OSC_LOW_CRYSTAL_OSC_2;
  assign is_lxt  = is_low_crystal_osc_1 || is_low_crystal_osc_2;

  // The clock output role exists only in RC modes; in crystal modes the
  // same pin carries the resonator, so the low mode bit only picks XT or HXT, or low crystal mode 1 or 2.
  assign rc_out_sel = is_rc && osc_code[0];
  assign prot_on    = |prot_bits;
  assign run_now    = state == ST_RUN;

  // The filter is bypassed by its own disable bit, by either low crystal
  // mode (the 32 kHz one included) and by sleep.
  assign nr_bypass = nr_dis_bit || is_lxt || sleep_mode_i;

  // Clocks per instruction for each period code.
  always_comb begin
    unique case (per_code)
      2'h0: per_clks = PER_CLK0;
      2'h1: per_clks = PER_CLK1;
      2'h2: per_clks = PER_CLK2;
      2'h3: per_clks = PER_CLK3;
    endcase
  end

  // The oscillator only sees trim and selector values in an RC mode; in
  // crystal modes it keeps the defaults so a stray code cannot disturb it.
  assign freq_eff = is_rc ? freq_raw : FREQ_DEF;
  assign trim_eff = is_rc ? trim_raw : TRIM_DEF;

  // Trim arithmetic and nominal rate lookup for the internal oscillator.
  owd_rc_trim u_trim (
    .trim_code_i   (trim_eff),
    .freq_sel_i    (freq_eff),
    .trim_step_o   (step_w),
    .nominal_khz_o (khz_w)
  );

  // Input noise filter on the external interrupt pin.
  owd_noise_filter #(
    .SHORT_CLKS (NR_SHORT),
    .LONG_CLKS  (NR_LONG)
  ) u_filter (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n),
    .pin_i       (ext_int_pin_i),
    .bypass_i    (nr_bypass),
    .short_sel_i (nr_short),
    .level_o     (filt_level),
    .fall_o      (filt_fall)
  );

  // Noise and interrupt outputs. All data outputs are registered; the option fields change once at capture,
  // while the filter activity follows sleep and the interrupt level and fall outputs follow the pin afterwards.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      noise_reject_mode_sel_o <= 1'b0;
      noise_pulse_width_sel_o <= 1'b0;
      noise_filter_disable_o  <= 1'b0;
      noise_filter_active_o   <= 1'b0;
      ext_int_level_o         <= 1'b1;
      ext_int_fall_o          <= 1'b0;
    end else begin
      noise_reject_mode_sel_o <= nr_mode;
      noise_pulse_width_sel_o <= nr_short;
      noise_filter_disable_o  <= nr_dis_bit;
      noise_filter_active_o   <= !nr_bypass;
      ext_int_level_o         <= filt_level;
      ext_int_fall_o          <= filt_fall;
    end
  end

  // Instruction timing, watchdog and code protection outputs.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      single_cycle_sel_o    <= 1'b0;
      instr_period_clks_o   <= PER_CLK0;
      watchdog_enable_opt_o <= 1'b0;
      code_protect_o        <= 1'b0;
    end else begin
      single_cycle_sel_o    <= cyc_one;
      instr_period_clks_o   <= per_clks;
      watchdog_enable_opt_o <= wdt_en;
      code_protect_o        <= prot_on;
    end
  end

  // Oscillator selection outputs. Only one class flag is ever high.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_mode_o          <= OSC_XT;
      crystal_osc_o       <= 1'b1;
      high_crystal_osc_o  <= 1'b0;
      low_crystal_osc_1_o <= 1'b0;
      low_crystal_osc_2_o <= 1'b0;
      internal_rc_osc_o   <= 1'b0;
      external_rc_osc_o   <= 1'b0;
      rc_clock_output_o   <= 1'b0;
    end else begin
      osc_mode_o          <= osc_code;
      crystal_osc_o       <= is_xt;
      high_crystal_osc_o  <= is_hxt;
      low_crystal_osc_1_o <= is_low_crystal_osc_1;
      low_crystal_osc_2_o <= is_low_crystal_osc_2;
      internal_rc_osc_o   <= is_irc;
      external_rc_osc_o   <= is_erc;
      rc_clock_output_o   <= rc_out_sel;
    end
  end

  // Internal RC controls, customer word and load status.
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rc_freq_sel_o    <= FREQ_DEF;
      rc_trim_code_o   <= TRIM_DEF;
      rc_trim_step_o   <= 6'sh00;
      rc_nominal_khz_o <= KHZ_SEL0;
      customer_id_o    <= W2_RESET;
      opt_loaded_o     <= 1'b0;
    end else begin
      rc_freq_sel_o    <= freq_eff;
      rc_trim_code_o   <= trim_eff;
      rc_trim_step_o   <= step_w;
      rc_nominal_khz_o <= khz_w;
      customer_id_o    <= word2;
      opt_loaded_o     <= run_now;
    end
  end

endmodule

/* File: owd_option_decoder_monitor.sv */
`timescale 1ns/1ps
module owd_option_decoder_monitor (
  input wire logic        core_clk_i,
  input wire logic        arst_n_i,
  input wire logic [12:0] opt_word0_i,
  input wire logic [12:0] opt_word1_i,
  input wire logic        sleep_mode_i,
  input wire logic        opt_loaded_o,
  input wire logic        noise_reject_mode_sel_o,
  input wire logic        noise_pulse_width_sel_o,
  input wire logic        noise_filter_active_o,
  input wire logic        ext_int_level_o,
  input wire logic        ext_int_fall_o,
  input wire logic        single_cycle_sel_o,
  input wire logic [4:0]  instr_period_clks_o,
  input wire logic        watchdog_enable_opt_o,
  input wire logic [2:0]  osc_mode_o,
  input wire logic        internal_rc_osc_o,
  input wire logic        rc_clock_output_o,
  input wire logic        code_protect_o,
  input wire logic [1:0]  rc_freq_sel_o,
  input wire logic [4:0]  rc_trim_code_o,
  input wire logic [13:0] rc_nominal_khz_o
);
  logic [12:0] w0c;
  logic [12:0] w1c;
  logic [4:0]  exp_per;
  logic        rc_mode;
  logic [1:0]  exp_sel;

  // Frozen copy of the words, so late input changes cannot mask a design
  // that follows its inputs after capture.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w0c <= 13'h0000;
      w1c <= 13'h1200;
    end else if (!opt_loaded_o) begin
      w0c <= opt_word0_i;
      w1c <= opt_word1_i;
    end
  end

  // Expected period and RC class from the frozen word.
  assign rc_mode = w0c[5];
  assign exp_sel = rc_mode ? w1c[3:2] : 2'h0;
  assign exp_per = w0c[8] ? (w0c[7] ? 5'h10 : 5'h08)
                          : (w0c[7] ? 5'h02 : 5'h04);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_load_in_time: assert property (
    $rose(arst_n_i) |-> !opt_loaded_o ##[1:12] opt_loaded_o)
    else $error("option words not loaded in time");
  a_hold_steady: assert property (opt_loaded_o |=> opt_loaded_o &&
    $stable(osc_mode_o) && $stable(rc_trim_code_o) &&
    $stable(instr_period_clks_o)) else $error("outputs moved after load");
  a_plain_bits: assert property (opt_loaded_o |->
    noise_reject_mode_sel_o == w0c[12] && noise_pulse_width_sel_o == w0c[11]
    && single_cycle_sel_o == w0c[9] && watchdog_enable_opt_o == w0c[6])
    else $error("single option bit wrong");
  a_period_table: assert property (
    opt_loaded_o |-> instr_period_clks_o == exp_per)
    else $error("instruction period wrong");
  a_osc_class: assert property (opt_loaded_o |->
    osc_mode_o == w0c[5:3] && internal_rc_osc_o == (w0c[5:4] == 2'h2))
    else $error("oscillator mode wrong");
  a_pin_role: assert property (
    opt_loaded_o |-> rc_clock_output_o == (w0c[5] && w0c[3]))
    else $error("clock output role wrong");
  a_protect_any: assert property (
    opt_loaded_o |-> code_protect_o == (|w0c[2:0]))
    else $error("code protection wrong");
  a_rc_gating: assert property (opt_loaded_o |->
    rc_trim_code_o == (rc_mode ? w1c[8:4] : 5'h00) &&
    rc_freq_sel_o == exp_sel)
    else $error("rc trim or selector wrong");
  a_nominal_rate: assert property (opt_loaded_o |->
    rc_nominal_khz_o == (exp_sel == 2'h0 ? 14'hfa0 :
    exp_sel == 2'h1 ? 14'h2ee0 :
    exp_sel == 2'h2 ? 14'hdfc : 14'h1c7))
    else $error("nominal rate wrong");
  a_filter_off: assert property (
    opt_loaded_o && $past(opt_loaded_o) |->
    noise_filter_active_o == !(w0c[10] || w0c[5:4] == 2'h1 ||
    $past(sleep_mode_i))) else $error("filter activity wrong");
  a_fall_once: assert property (
    $fell(ext_int_level_o) |-> ext_int_fall_o ##1 !ext_int_fall_o)
    else $error("fall pulse wrong");

  c_irc: cover property (opt_loaded_o && internal_rc_osc_o);
  c_fall: cover property (ext_int_fall_o && noise_filter_active_o);
  c_prot: cover property (opt_loaded_o && code_protect_o);
endmodule

bind owd_option_decoder owd_option_decoder_monitor u_mon (
  .core_clk_i, .arst_n_i, .opt_word0_i, .opt_word1_i, .sleep_mode_i,
  .opt_loaded_o, .noise_reject_mode_sel_o, .noise_pulse_width_sel_o,
  .noise_filter_active_o, .ext_int_level_o, .ext_int_fall_o,
  .single_cycle_sel_o, .instr_period_clks_o, .watchdog_enable_opt_o,
  .osc_mode_o, .internal_rc_osc_o, .rc_clock_output_o, .code_protect_o,
  .rc_freq_sel_o, .rc_trim_code_o, .rc_nominal_khz_o);

/* File: test_owd_option_decoder.sv */
`timescale 1ns/1ps
module test_owd_option_decoder;
  import owd_pkg::*;
  logic core_clk_i, arst_n_i, sleep_mode_i, ext_int_pin_i;
  logic [12:0] opt_word0_i, opt_word1_i, opt_word2_i, customer_id_o;
  logic opt_loaded_o, noise_reject_mode_sel_o, noise_pulse_width_sel_o;
  logic noise_filter_disable_o, noise_filter_active_o, ext_int_level_o;
  logic ext_int_fall_o, single_cycle_sel_o, watchdog_enable_opt_o;
  logic crystal_osc_o, high_crystal_osc_o, low_crystal_osc_1_o;
  logic low_crystal_osc_2_o, internal_rc_osc_o, external_rc_osc_o;
  logic rc_clock_output_o, code_protect_o;
  logic [4:0] instr_period_clks_o, rc_trim_code_o;
  logic [2:0] osc_mode_o;
  logic [1:0] rc_freq_sel_o;
  logic signed [5:0] rc_trim_step_o;
  logic [13:0] rc_nominal_khz_o;
  int fails = 0;
  int n_tests = 0;

  owd_option_decoder u_dut (.core_clk_i, .arst_n_i, .opt_word0_i,
    .opt_word1_i, .opt_word2_i, .sleep_mode_i, .ext_int_pin_i, .opt_loaded_o,
    .customer_id_o, .noise_reject_mode_sel_o, .noise_pulse_width_sel_o,
    .noise_filter_disable_o, .noise_filter_active_o, .ext_int_level_o,
    .ext_int_fall_o, .single_cycle_sel_o, .instr_period_clks_o,
    .watchdog_enable_opt_o, .osc_mode_o, .crystal_osc_o, .high_crystal_osc_o,
    .low_crystal_osc_1_o, .low_crystal_osc_2_o, .internal_rc_osc_o,
    .external_rc_osc_o, .rc_clock_output_o, .code_protect_o, .rc_freq_sel_o,
    .rc_trim_code_o, .rc_trim_step_o, .rc_nominal_khz_o);

  // Free-running core clock at 125 MHz.
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_v(input logic [13:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Inputs always move one nanosecond after the edge, never on it.
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Reset with new words, then wait a bounded time for the capture.
  task automatic rst(input logic [12:0] a, b, c, input int hold);
    int k;
    arst_n_i = 1'b0;
    opt_word0_i = a;
    opt_word1_i = b;
    opt_word2_i = c;
    tk(hold);
    arst_n_i = 1'b1;
    for (k = 0; k < 20 && opt_loaded_o !== 1'b1; k++) tk(1);
    if (opt_loaded_o !== 1'b1) begin
      fails++;
      $display("MISMATCH at %0t: load timed out", $time);
      give_verdict();
    end
  endtask

  task automatic t_defaults;
    tk(19);
    chk_v({opt_loaded_o, crystal_osc_o, ext_int_level_o},
          3'h3, "dflt");
    chk_v(instr_period_clks_o, 5'h04, "dflt period");
    chk_v(rc_nominal_khz_o, 14'hfa0, "dflt rate");
    rst(13'h0000, 13'h1200, 13'h0000, 1);
    $display("test defaults done");
  endtask

  task automatic t_configs;
    logic [4:0] codes [8] = '{5'h1f, 5'h17, 5'h00, 5'h08,
                              5'h1f, 5'h17, 5'h00, 5'h08};
    logic [4:0] pt [4] = '{5'h04, 5'h02, 5'h08, 5'h10};
    logic [13:0] kt [4] = '{14'hfa0, 14'h2ee0, 14'hdfc, 14'h1c7};
    logic [12:0] a, b, c;
    logic [4:0] md;
    logic [5:0] es;
    logic [2:0] i;
    for (int n = 0; n < 8; n++) begin
      i = n[2:0];
      a = {i[0], i[1], i[2], i[0], i[1:0], i[2], i, i};
      b = {4'h9, codes[n], i[1:0], 2'h0};
      c = 13'h1abc ^ {10'h000, i};
      rst(a, b, c, 3);
      md = i[2] ? codes[n] : 5'h00;
      es = md[3] ? ~{2'h0, md[4], md[2:0]} : {2'h0, md[4], md[2:0]};
      chk_v(osc_mode_o, i, "osc");
      chk_v({crystal_osc_o, high_crystal_osc_o, low_crystal_osc_1_o,
             low_crystal_osc_2_o, internal_rc_osc_o, external_rc_osc_o},
            {i == 0, i == 1, i == 2, i == 3, i[2:1] == 2'h2,
             i[2:1] == 2'h3}, "osc class");
      chk_v(rc_clock_output_o, i[2] & i[0], "clk out");
      chk_v(instr_period_clks_o, pt[i[1:0]], "period");
      chk_v(code_protect_o, i != 0, "protect");
      chk_v({noise_reject_mode_sel_o,
             noise_pulse_width_sel_o, noise_filter_disable_o,
             single_cycle_sel_o, watchdog_enable_opt_o},
            {i[0], i[1], i[2], i[0], i[2]}, "bits");
      chk_v(noise_filter_active_o, !(i[2] | i == 2 | i == 3), "nf");
      chk_v(rc_freq_sel_o, i[2] ? i[1:0] : 2'h0, "fsel");
      chk_v(rc_trim_code_o, md, "trim");
      chk_v({rc_trim_step_o}, es, "step");
      chk_v(rc_nominal_khz_o, kt[i[2] ? i[1:0] : 2'h0], "rate");
      chk_v(customer_id_o, c, "id");
      opt_word0_i = ~a;
      opt_word1_i = ~b;
      tk(10);
      chk_v({osc_mode_o, rc_trim_code_o}, {i, md}, "held");
    end
    $display("test configs done");
  endtask

  // One low pulse of len cycles; counts one-cycle fall pulses seen.
  task automatic t_pulse(input logic [12:0] a, input logic sl,
                         input int len, input int exp_n, input logic act);
    logic [13:0] cnt;
    logic        lo;
    cnt = 14'h0000;
    lo = 1'b1;
    sleep_mode_i = sl;
    rst(a, 13'h1200, 13'h0000, 3);
    tk(3);
    chk_v(noise_filter_active_o, act, "active");
    ext_int_pin_i = 1'b0;
    for (int k = 0; k < len + 60; k++) begin
      if (k == len) ext_int_pin_i = 1'b1;
      tk(1);
      cnt += ext_int_fall_o;
      lo &= ext_int_level_o;
    end
    chk_v(cnt, exp_n, "fall count");
    chk_v(lo, exp_n == 0, "level held");
    chk_v(ext_int_level_o, 1'b1, "level back");
    sleep_mode_i = 1'b0;
  endtask

  task automatic t_filter;
    t_pulse(13'h0800, 1'b0, 6, 0, 1'b1);
    t_pulse(13'h0800, 1'b0, 12, 1, 1'b1);
    t_pulse(13'h0000, 1'b0, 28, 0, 1'b1);
    t_pulse(13'h0000, 1'b0, 40, 1, 1'b1);
    t_pulse(13'h0400, 1'b0, 3, 1, 1'b0);
    t_pulse(13'h0010, 1'b0, 3, 1, 1'b0);
    t_pulse(13'h0018, 1'b0, 3, 1, 1'b0);
    t_pulse(13'h0000, 1'b1, 3, 1, 1'b0);
    $display("test filter done");
  endtask

  // Main sequence; every input has a value at time zero.
  initial begin
    arst_n_i = 1'b0;
    sleep_mode_i = 1'b0;
    ext_int_pin_i = 1'b1;
    opt_word0_i = 13'h0000;
    opt_word1_i = 13'h1200;
    opt_word2_i = 13'h0000;
    t_defaults();
    t_configs();
    t_filter();
    give_verdict();
  end
endmodule
